// File: hdl/dlc_pkg.sv
package dlc_pkg;
  // register offsets of the controller's own apb slave
  localparam logic [11:0] DLC_OFF_CTRL = 12'h000;   // mode selection, bit 0 two's complement
  localparam logic [11:0] DLC_OFF_DATA = 12'h004;   // 12-bit code to send
  localparam logic [11:0] DLC_OFF_CMD = 12'h008;    // write starts an operation
  localparam logic [11:0] DLC_OFF_STAT = 12'h00c;   // busy, done, last code
  localparam logic [11:0] DLC_OFF_RST = 12'h010;    // device reset level
  // ctrl field positions
  localparam int DLC_CTRL_TWOS = 0;                 // host inverts msb for two's complement
  localparam int DLC_CTRL_WIDTH = 2;
  // command codes (low bits of a cmd write)
  localparam logic [2:0] DLC_CMD_LOW = 3'h1;        // load low byte latch
  localparam logic [2:0] DLC_CMD_HIGH = 3'h2;       // load high nibble latch
  localparam logic [2:0] DLC_CMD_XFER = 3'h3;       // transfer input latches to d/a latch
  localparam logic [2:0] DLC_CMD_FULL = 3'h4;       // low, high then transfer
  localparam logic [2:0] DLC_CMD_THRU = 3'h5;       // all latches transparent at once
  // status bits
  localparam int DLC_STAT_BUSY = 0;
  localparam int DLC_STAT_DONE = 1;
  localparam int DLC_STAT_CODE = 4;                 // last code sent, 12 bits
  // reset values
  localparam logic [11:0] DLC_DATA_RST = 12'h000;
  localparam logic [1:0] DLC_CTRL_RST = 2'h0;
  localparam logic [11:0] DLC_MID_SCALE = 12'h800;  // code the device holds after its reset
  // strobe timing
  localparam int DLC_CLK_NS = 20;
  localparam int DLC_SETUP_NS = 60;                 // data before strobes
  localparam int DLC_PULSE_NS = 100;                // strobe low width
  localparam int DLC_HOLD_NS = 40;                  // data after strobes
  localparam logic [3:0] DLC_SETUP_CYC = 4'((DLC_SETUP_NS + DLC_CLK_NS - 1) / DLC_CLK_NS);
  localparam logic [3:0] DLC_PULSE_CYC = 4'((DLC_PULSE_NS + DLC_CLK_NS - 1) / DLC_CLK_NS);
  localparam logic [3:0] DLC_HOLD_CYC = 4'((DLC_HOLD_NS + DLC_CLK_NS - 1) / DLC_CLK_NS);
  // sequencer states
  typedef enum logic [2:0] {DLC_IDLE, DLC_SETUP, DLC_PULSE, DLC_HOLD} dlc_state_t;
endpackage

// File: hdl/dlc_strobe_seq.sv
`timescale 1ns/1ps
// drives one strobe cycle on the device pins: setup, low pulse, hold
module dlc_strobe_seq
  import dlc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [11:0] code,
  input wire logic en_low,
  input wire logic en_high,
  input wire logic en_dac,
  output logic [11:0] pin_data,
  output logic wr_n,
  output logic low_n,
  output logic high_n,
  output logic dac_n,
  output logic busy,
  output logic finish
);
  dlc_state_t state_reg, state_next;  // sequencer state
  logic [3:0] cnt_reg, cnt_next;      // cycle counter
  logic [11:0] data_reg;              // data lines held through the cycle
  logic [2:0] sel_reg;                // selected latch enables
  logic last;                         // counter expired
  logic strobe;                       // strobes active this cycle
  logic accept;                       // start taken: idle, or back to back at end of hold

  assign last = (cnt_reg == 4'h1);
  assign strobe = (state_reg == DLC_PULSE);
  assign busy = (state_reg != DLC_IDLE);
  assign finish = (state_reg == DLC_HOLD) && last;
  // a start in the last hold cycle chains the next cycle without losing it
  assign accept = start && ((state_reg == DLC_IDLE) || finish);
  assign pin_data = data_reg;
  // write strobe low in every transfer, enables only together with it
  assign wr_n = !strobe;
  assign low_n = !(strobe && sel_reg[0]);
  assign high_n = !(strobe && sel_reg[1]);
  assign dac_n = !(strobe && sel_reg[2]);

  // next state
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      DLC_IDLE:
      begin
        if (start)
        begin
          state_next = DLC_SETUP;
          cnt_next = DLC_SETUP_CYC;
        end
      end
      DLC_SETUP:
      begin
        cnt_next = cnt_reg - 4'h1;
        if (last)
        begin
          state_next = DLC_PULSE;
          cnt_next = DLC_PULSE_CYC;
        end
      end
      DLC_PULSE:
      begin
        cnt_next = cnt_reg - 4'h1;
        // strobes rise together so data is captured stable
        if (last)
        begin
          state_next = DLC_HOLD;
          cnt_next = DLC_HOLD_CYC;
        end
      end
      DLC_HOLD:
      begin
        cnt_next = cnt_reg - 4'h1;
        if (last && start)
        begin
          // next cycle follows at once, strobes stay high in between
          state_next = DLC_SETUP;
          cnt_next = DLC_SETUP_CYC;
        end
        else if (last)
        begin
          state_next = DLC_IDLE;
          cnt_next = 4'h0;
        end
      end
      default:
      begin
        state_next = DLC_IDLE;
        cnt_next = 4'h0;
      end
    endcase
  end

  // state registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= DLC_IDLE;
      cnt_reg <= 4'h0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // data and selection captured at start, held until the next start is taken
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_reg <= 12'h000;
      sel_reg <= 3'h0;
    end
    else if (accept)
    begin
      data_reg <= code;
      sel_reg <= {en_dac, en_high, en_low};
    end
  end
endmodule

// File: hdl/dlc_dac_host.sv
`timescale 1ns/1ps
module dlc_dac_host
  import dlc_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic [11:0] DAC_DATA,
  output logic DAC_WR_N,
  output logic DAC_LOAD_N,
  output logic HIGH_NIBBLE_LATCH_EN_N,
  output logic LOW_BYTE_LATCH_EN_N,
  output logic DAC_RESET_N
);

  ////////////////////////////////////////////////////////////////////////////
  // decoding

  // address decoder, shared by read and write paths
  function automatic logic [2:0] dlc_dec(input logic [11:0] a);
    case (a)
      DLC_OFF_CTRL: dlc_dec = 3'h1;
      DLC_OFF_DATA: dlc_dec = 3'h2;
      DLC_OFF_CMD: dlc_dec = 3'h3;
      DLC_OFF_STAT: dlc_dec = 3'h4;
      DLC_OFF_RST: dlc_dec = 3'h5;
      default: dlc_dec = 3'h0;
    endcase
  endfunction

  logic access;              // apb access phase
  logic [2:0] sel;           // decoded register
  logic wr;                  // write taken this edge
  logic [1:0] ctrl_reg;      // mode bits
  logic [11:0] data_reg;     // code to send
  logic rst_reg;             // device reset level, high = reset asserted
  logic done_reg;            // sticky done flag
  logic [11:0] sent_reg;     // last code placed in d/a latch
  logic [2:0] phase_reg;     // command phase, 0 idle
  logic [2:0] phase_next;
  logic [11:0] code;         // word on the pins after coding
  logic seq_start;           // start strobe sequencer
  logic seq_busy;            // sequencer busy
  logic seq_finish;          // sequencer cycle done
  logic en_low;              // select low byte latch
  logic en_high;             // select high nibble latch
  logic en_dac;              // select d/a latch
  logic busy;                // any operation running
  logic cmd_go;              // valid command written
  logic [2:0] cmd;           // command code written
  // register selects and strobes from the bus and the sequencer
  logic sel_ctrl;            // ctrl register addressed
  logic sel_data;            // data register addressed
  logic sel_cmd;             // command register addressed
  logic sel_stat;            // status register addressed
  logic sel_rst;             // reset register addressed
  logic rd_stat;             // status read taken this edge, clears done
  logic set_done;            // last sequencer cycle of a command ends
  logic cmd_valid;           // command code within the known set
  // copies of what the device latches hold
  logic [7:0] low_mirror_reg;   // device low byte latch
  logic [3:0] high_mirror_reg;  // device high nibble latch
  logic [11:0] dac_word;        // word the d/a latch takes on this load

  assign access = PSEL && PENABLE;
  assign sel = dlc_dec(PADDR);
  assign wr = access && PWRITE;
  assign PREADY = 1'b1;                          // zero wait states
  assign PSLVERR = access && (sel == 3'h0);      // unmapped address
  assign cmd = PWDATA[2:0];
  // one named select per register
  assign sel_ctrl = (sel == 3'h1);
  assign sel_data = (sel == 3'h2);
  assign sel_cmd = (sel == 3'h3);
  assign sel_stat = (sel == 3'h4);
  assign sel_rst = (sel == 3'h5);
  // status read strobe and end of a whole command
  assign rd_stat = access && !PWRITE && sel_stat;
  assign set_done = ((phase_reg == 3'h3) || (phase_reg == 3'h4)) && seq_finish;
  assign busy = seq_busy || (phase_reg != 3'h0);
  // codes 1 to 5 only; anything else is dropped without a trace
  assign cmd_valid = (cmd >= DLC_CMD_LOW) && (cmd <= DLC_CMD_THRU);
  // commands while busy or in reset are ignored, so no new strobe
  // reaches a device held in reset
  assign cmd_go = wr && sel_cmd && !busy && !rst_reg && cmd_valid;

  ////////////////////////////////////////////////////////////////////////////
  // coding

  // msb inverted for two's complement, offset binary otherwise
  // d11 msb, d0 lsb, all positive true
  // 000 zero or minus fs, 800 zero bipolar, fff plus fs
  assign code = {data_reg[11] ^ ctrl_reg[DLC_CTRL_TWOS], data_reg[10:0]};

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  // mode bits, written any time, used from the next strobe cycle on
  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      ctrl_reg <= DLC_CTRL_RST;                  // offset binary after reset
    else if (wr && sel_ctrl)
      ctrl_reg <= PWDATA[DLC_CTRL_WIDTH-1:0];
  end

  // code to send; a running cycle keeps its own copy in the sequencer
  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      data_reg <= DLC_DATA_RST;
    else if (wr && sel_data)
      data_reg <= PWDATA[11:0];
  end

  // device reset level; asserted from power-up until software lets go
  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      rst_reg <= 1'b1;                           // device held at mid-scale
    else if (wr && sel_rst)
      rst_reg <= PWDATA[0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing

  // phase: 0 idle, 1..3 steps of full load, 4 single command
  always_comb
  begin
    phase_next = phase_reg;
    seq_start = 1'b0;
    en_low = 1'b0;
    en_high = 1'b0;
    en_dac = 1'b0;
    case (phase_reg)
      3'h0:
      begin
        if (cmd_go)
        begin
          seq_start = 1'b1;
          phase_next = (cmd == DLC_CMD_FULL) ? 3'h1 : 3'h4;
          en_low = (cmd == DLC_CMD_LOW) || (cmd == DLC_CMD_FULL)
                   || (cmd == DLC_CMD_THRU);
          en_high = (cmd == DLC_CMD_HIGH) || (cmd == DLC_CMD_THRU);
          // all three enables together: transparent path
          en_dac = (cmd == DLC_CMD_XFER) || (cmd == DLC_CMD_THRU);
        end
      end
      3'h1:
      begin
        // low byte loaded, now high nibble
        if (seq_finish && rst_reg)
          phase_next = 3'h0;                     // device reset meanwhile: abandon
        else if (seq_finish)
        begin
          seq_start = 1'b1;
          en_high = 1'b1;
          phase_next = 3'h2;
        end
      end
      3'h2:
      begin
        // both input latches full, transfer as one word
        if (seq_finish && rst_reg)
          phase_next = 3'h0;                     // device reset meanwhile: abandon
        else if (seq_finish)
        begin
          seq_start = 1'b1;
          en_dac = 1'b1;
          phase_next = 3'h3;
        end
      end
      3'h3, 3'h4:
      begin
        if (seq_finish)
          phase_next = 3'h0;
      end
      default:
        phase_next = 3'h0;
    endcase
  end

  // command phase
  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      phase_reg <= 3'h0;                         // idle
    else
      phase_reg <= phase_next;
  end

  // sticky done: set wins over the read that would clear it
  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      done_reg <= 1'b0;
    else if (set_done)
      done_reg <= 1'b1;                          // last cycle of a command ends
    else if (rd_stat)
      done_reg <= 1'b0;                          // status read clears
  end

  // copies of the input latches, taken when a cycle selecting them starts;
  // the device keeps them through its own reset, so they do too
  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      low_mirror_reg <= DLC_MID_SCALE[7:0];      // unknown in the device
      high_mirror_reg <= DLC_MID_SCALE[11:8];
    end
    else if (seq_start)
    begin
      if (en_low)
        low_mirror_reg <= code[7:0];
      if (en_high)
        high_mirror_reg <= code[11:8];
    end
  end

  // word the d/a latch takes: fresh lines where an input latch is open
  // in the same cycle, latch contents otherwise
  assign dac_word = {en_high ? code[11:8] : high_mirror_reg,
                     en_low ? code[7:0] : low_mirror_reg};

  // code now in the d/a latch, as software reads it in the status word
  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      sent_reg <= DLC_MID_SCALE;
    else if (rst_reg)
      sent_reg <= DLC_MID_SCALE;                 // device reset gives mid-scale
    else if (seq_start && en_dac)
      sent_reg <= dac_word;
  end

  // reset level driven while asserted; no command starts strobes then, a cycle already running finishes
  assign DAC_RESET_N = !rst_reg;

  ////////////////////////////////////////////////////////////////////////////
  // read data

  logic [31:0] rd_ctrl_word;    // control word as read
  logic [31:0] rd_data_word;    // data word as read
  logic [31:0] rd_status_word;  // status word: code, done, busy
  logic [31:0] rd_rst_word;     // reset word as read
  logic [31:0] rdata;           // selected read value

  // each readable word built on its own, zeros in the unused bits
  assign rd_ctrl_word = {30'h0, ctrl_reg};
  assign rd_data_word = {20'h0, data_reg};
  assign rd_status_word = {16'h0, sent_reg, 2'h0, done_reg, busy};
  assign rd_rst_word = {31'h0, rst_reg};

  // one word per address; the command register and holes read as zero
  assign rdata = sel_ctrl ? rd_ctrl_word :
                 sel_data ? rd_data_word :
                 sel_stat ? rd_status_word :
                 sel_rst ? rd_rst_word : 32'h0;
  assign PRDATA = rdata;

  ////////////////////////////////////////////////////////////////////////////
  // pin sequencer

  dlc_strobe_seq u_seq
  (
    .clk(REF_CLK),
    .rst_n(RESET_N),
    .start(seq_start),
    .code(code),
    .en_low(en_low),
    .en_high(en_high),
    .en_dac(en_dac),
    .pin_data(DAC_DATA),
    .wr_n(DAC_WR_N),
    .low_n(LOW_BYTE_LATCH_EN_N),
    .high_n(HIGH_NIBBLE_LATCH_EN_N),
    .dac_n(DAC_LOAD_N),
    .busy(seq_busy),
    .finish(seq_finish)
  );
endmodule

// File: tb/dlc_dac_host_checker.sv
`timescale 1ns/1ps
// pin and register checks on the host controller
module dlc_dac_host_checker
  import dlc_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [11:0] DAC_DATA,
  input wire logic DAC_WR_N,
  input wire logic DAC_LOAD_N,
  input wire logic HIGH_NIBBLE_LATCH_EN_N,
  input wire logic LOW_BYTE_LATCH_EN_N,
  input wire logic DAC_RESET_N
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  a_enable_needs_wr: assert property ((!DAC_LOAD_N || !HIGH_NIBBLE_LATCH_EN_N
    || !LOW_BYTE_LATCH_EN_N) |-> !DAC_WR_N) else $error("enable low without write");
  a_load_with_wr: assert property ($fell(DAC_LOAD_N) |-> $fell(DAC_WR_N))
    else $error("load strobe apart from write");
  a_high_with_wr: assert property ($fell(HIGH_NIBBLE_LATCH_EN_N) |-> $fell(DAC_WR_N))
    else $error("high enable apart from write");
  a_low_with_wr: assert property ($fell(LOW_BYTE_LATCH_EN_N) |-> $fell(DAC_WR_N))
    else $error("low enable apart from write");
  a_pulse_width: assert property ($fell(DAC_WR_N) |-> !DAC_WR_N [*5] ##1 DAC_WR_N)
    else $error("write pulse width");
  a_data_hold: assert property ((!DAC_WR_N || !$past(DAC_WR_N)
    || !$past(DAC_WR_N, 2)) |-> $stable(DAC_DATA)) else $error("data moved near strobe");
  a_reset_pin: assert property ((PSEL && PENABLE && PWRITE && PADDR == DLC_OFF_RST)
    |=> DAC_RESET_N == !$past(PWDATA[0])) else $error("device reset pin");
  a_no_strobe_rst: assert property ($fell(DAC_WR_N) |-> DAC_RESET_N)
    else $error("strobe while device in reset");
endmodule

// File: tb/dlc_dev_model.sv
`timescale 1ns/1ps
// level-sensitive input and d/a latches of the converter
module dlc_dev_model
(
  input wire logic [11:0] data,
  input wire logic wr_n,
  input wire logic load_n,
  input wire logic high_n,
  input wire logic low_n,
  input wire logic rst_n,
  output logic [11:0] code
);
  logic [7:0] low_reg; // low byte latch, no reset
  logic [3:0] high_reg; // high nibble latch, no reset
  // low byte latch follows d0..d7 while both strobes low
  always_latch
    if (!wr_n && !low_n) low_reg <= data[7:0];
  // high nibble latch follows d8..d11
  always_latch
    if (!wr_n && !high_n) high_reg <= data[11:8];
  // d/a latch, reset wins over every strobe, offset binary code
  always_latch
    if (!rst_n) code <= 12'h800;
    else if (!wr_n && !load_n) code <= {high_reg, low_reg};
endmodule

// File: tb/dlc_dac_host_tb.sv
`timescale 1ns/1ps
module dlc_dac_host_tb import dlc_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  logic [11:0] dac_data, code;
  logic wr_n, load_n, high_n, low_n, dev_rst_n;
  int n_mismatch = 0;
  int checked = 0;
  dlc_dac_host dut_u (.REF_CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .DAC_DATA(dac_data), .DAC_WR_N(wr_n), .DAC_LOAD_N(load_n),
    .HIGH_NIBBLE_LATCH_EN_N(high_n), .LOW_BYTE_LATCH_EN_N(low_n), .DAC_RESET_N(dev_rst_n));
  dlc_dev_model dev_u (.data(dac_data), .wr_n(wr_n), .load_n(load_n), .high_n(high_n),
    .low_n(low_n), .rst_n(dev_rst_n), .code(code));
  initial
    forever #10 clk = ~clk;
  task end_of_test;
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer, held until pready, read data taken at that edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // load data, issue command, poll busy under a bound; ok: command is taken
  task run(input logic [2:0] c, input logic [11:0] d, input logic ok);
    apb(1'b1, DLC_OFF_DATA, {20'h0, d});
    apb(1'b1, DLC_OFF_CMD, {29'h0, c});
    rd = 32'h1;
    for (int i = 0; i < 50 && rd[DLC_STAT_BUSY] !== 1'b0; i++) apb(1'b0, DLC_OFF_STAT, 32'h0);
    chk("busy", rd[DLC_STAT_BUSY], 32'h0);
    chk("done", rd[DLC_STAT_DONE], {31'h0, ok});
    apb(1'b0, DLC_OFF_STAT, 32'h0);
    chk("done cleared", rd[DLC_STAT_DONE], 32'h0);
  endtask
  // device held in reset ignores a full command
  task t_reset;
    apb(1'b0, DLC_OFF_STAT, 32'h0);
    chk("stat code", rd[15:4], DLC_MID_SCALE);
    run(DLC_CMD_FULL, 12'h5a5, 1'b0);
    chk("code in reset", code, 12'h800);
    apb(1'b1, DLC_OFF_RST, 32'h0);
  endtask
  // partial loads leave the output alone until transfer
  task t_partial;
    run(DLC_CMD_LOW, 12'habc, 1'b1);
    chk("after low", code, 12'h800);
    run(DLC_CMD_HIGH, 12'h5f0, 1'b1);
    chk("after high", code, 12'h800);
    run(DLC_CMD_XFER, 12'h000, 1'b1);
    chk("after xfer", code, 12'h5bc);
    apb(1'b0, DLC_OFF_STAT, 32'h0);
    chk("stat after xfer", rd[15:4], 12'h5bc);
  endtask
  // code end points, transparent mode
  task t_codes;
    logic [11:0] tbl [4];
    tbl = '{12'h000, 12'hfff, 12'h800, 12'h7ff};
    foreach (tbl[i])
    begin
      run(DLC_CMD_FULL, tbl[i], 1'b1);
      chk("full code", code, tbl[i]);
    end
    run(DLC_CMD_THRU, 12'h3c5, 1'b1);
    chk("thru code", code, 12'h3c5);
  endtask
  // two's complement, reset again, unmapped access
  task t_misc;
    apb(1'b1, DLC_OFF_CTRL, 32'h1);
    run(DLC_CMD_FULL, 12'h123, 1'b1);
    chk("twos code", code, 12'h923);
    apb(1'b1, DLC_OFF_CTRL, 32'h0);
    apb(1'b1, DLC_OFF_RST, 32'h1);
    @(posedge clk);
    chk("code reset again", code, 12'h800);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped err", err, 32'h1);
    chk("unmapped data", rd, 32'h0);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_partial;
    t_codes;
    t_misc;
    end_of_test;
  end
  // hang guard, well above the expected few hundred cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_of_test;
  end
endmodule
bind dlc_dac_host dlc_dac_host_checker chk_u (.REF_CLK(REF_CLK), .RESET_N(RESET_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .DAC_DATA(DAC_DATA), .DAC_WR_N(DAC_WR_N), .DAC_LOAD_N(DAC_LOAD_N),
  .HIGH_NIBBLE_LATCH_EN_N(HIGH_NIBBLE_LATCH_EN_N), .LOW_BYTE_LATCH_EN_N(LOW_BYTE_LATCH_EN_N),
  .DAC_RESET_N(DAC_RESET_N));
